//--- src/pio_port.sv
// programmable i/o port: drive modes, config forms, edge interrupts, reset load
`timescale 1ns/1ns
module pio_port
    import pio_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] nvResetCfg,
    input wire logic [PIO_PINS-1:0] portWrEn,
    input wire logic [2:0] portWrSel,
    input wire logic [PIO_PINS-1:0] portWrData,
    input wire logic pinWrEn,
    input wire logic [2:0] pinWrIdx,
    input wire logic [7:0] pinWrData,
    input wire logic [2:0] pinRdIdx,
    output logic [7:0] pinRdData,
    input wire logic [PIO_AUX_W-1:0] auxOe,
    input wire logic [PIO_PINS*PIO_SEL_W-1:0] auxSel,
    input wire logic [2*PIO_PINS-1:0] intType,
    input wire logic intStatClr,
    input wire logic lowPower,
    input wire logic lvttlSel,
    input wire logic [2*PIO_PAIRS-1:0] pairThreshSel,
    input wire logic [PIO_PINS-1:0] pinIn,
    output logic [PIO_PINS-1:0] pinOut,
    output logic [PIO_PINS-1:0] pinOe_n,
    output pio_drive_t [PIO_PINS-1:0] pinDrive,
    output logic [PIO_PINS-1:0] inBufEn,
    output logic thresholdLvttl,
    output logic [2*PIO_PAIRS-1:0] pairThresh,
    output logic [PIO_PINS-1:0] pinStateRead,
    output logic [PIO_PINS-1:0] intStatus,
    output logic portIrq,
    output logic cfgLoaded
);
    // ============================================================
    // decode helpers
    function automatic logic edgeHit(input logic [1:0] sel, input logic cur, input logic prev);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = ~cur & prev;
        unique case (sel)
            INT_OFF: edgeHit = 1'b0;
            INT_RISE: edgeHit = rise;
            INT_FALL: edgeHit = fall;
            INT_BOTH: edgeHit = rise | fall;
        endcase
    endfunction : edgeHit
    function automatic logic [2:0] resetMode(input logic [1:0] cfg);
        unique case (cfg)
            RST_CFG_PULLDN: resetMode = DM_PULLDN;
            RST_CFG_PULLUP: resetMode = DM_PULLUP;
            default: resetMode = DM_ANALOG;
        endcase
    endfunction : resetMode
    // ============================================================
    // configuration state shared by both register forms
    pio_cfg_t cfg_q;
    pio_cfg_t cfg_d;
    pio_load_t load_q;
    pio_load_t load_d;
    logic [1:0] rstCfg_q;
    logic [1:0] rstCfg_d;
    logic lvttl_q;
    logic lvttl_d;
    logic [2*PIO_PAIRS-1:0] pairTh_q;
    logic [2*PIO_PAIRS-1:0] pairTh_d;
    always_comb begin
        cfg_d = cfg_q;
        load_d = load_q;
        rstCfg_d = rstCfg_q;
        lvttl_d = lvttlSel;
        pairTh_d = pairThreshSel;
        unique case (load_q)
            PIO_LOAD_IDLE: begin
                rstCfg_d = nvResetCfg;
                load_d = PIO_LOAD_COPY;
            end
            PIO_LOAD_COPY: begin
                for (int i = 0; i < PIO_PINS; i++) begin
                    {cfg_d.dm2[i], cfg_d.dm1[i], cfg_d.dm0[i]} = resetMode(rstCfg_q);
                end
                load_d = PIO_LOAD_DONE;
            end
            PIO_LOAD_DONE: begin
                for (int i = 0; i < PIO_PINS; i++) begin
                    if (portWrEn[i]) begin
                        unique case (portWrSel)
                            3'h0: cfg_d.outData[i] = portWrData[i];
                            3'h1: cfg_d.dm0[i] = portWrData[i];
                            3'h2: cfg_d.dm1[i] = portWrData[i];
                            3'h3: cfg_d.dm2[i] = portWrData[i];
                            3'h4: cfg_d.slew[i] = portWrData[i];
                            3'h5: cfg_d.bidirEn[i] = portWrData[i];
                            3'h6: cfg_d.inBufDis[i] = portWrData[i];
                            3'h7: cfg_d.vselReg[i] = portWrData[i];
                        endcase
                    end
                end
                if (pinWrEn) begin
                    cfg_d.outData[pinWrIdx] = pinWrData[PF_OUT];
                    cfg_d.dm0[pinWrIdx] = pinWrData[PF_DM_LSB];
                    cfg_d.dm1[pinWrIdx] = pinWrData[PF_DM_LSB+1];
                    cfg_d.dm2[pinWrIdx] = pinWrData[PF_DM_LSB+2];
                    cfg_d.slew[pinWrIdx] = pinWrData[PF_SLW];
                    cfg_d.bidirEn[pinWrIdx] = pinWrData[PF_BIE];
                    cfg_d.inBufDis[pinWrIdx] = pinWrData[PF_IBD];
                    cfg_d.vselReg[pinWrIdx] = pinWrData[PF_VSEL];
                end
            end
            default: load_d = PIO_LOAD_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= '0; // analog until loaded
            load_q <= PIO_LOAD_IDLE;
            rstCfg_q <= RST_CFG_ANALOG;
            lvttl_q <= 1'b0;
            pairTh_q <= {PIO_PAIRS{VTH_HALF_VDD}};
        end else begin
            cfg_q <= cfg_d; // held regardless of lowPower
            load_q <= load_d;
            rstCfg_q <= rstCfg_d;
            lvttl_q <= lvttl_d;
            pairTh_q <= pairTh_d;
        end
    end
    assign cfgLoaded = (load_q == PIO_LOAD_DONE);
    assign thresholdLvttl = lvttl_q;
    assign pairThresh = pairTh_q;
    always_comb begin
        pinRdData = {cfg_q.vselReg[pinRdIdx], cfg_q.inBufDis[pinRdIdx],
            cfg_q.bidirEn[pinRdIdx], cfg_q.slew[pinRdIdx], cfg_q.dm2[pinRdIdx],
            cfg_q.dm1[pinRdIdx], cfg_q.dm0[pinRdIdx], cfg_q.outData[pinRdIdx]};
    end
    // ============================================================
    // pin drivers
    logic [PIO_PINS-1:0] driveOn;
    logic [PIO_PINS-1:0] bufOn;
    generate
        for (genvar p = 0; p < PIO_PINS; p++) begin : g_pin
            logic [2:0] mode;
            logic [2:0] effMode;
            logic oeSig;
            logic d;
            assign mode = {cfg_q.dm2[p], cfg_q.dm1[p], cfg_q.dm0[p]};
            assign oeSig = auxOe[auxSel[p*PIO_SEL_W +: 4]] & auxSel[p*PIO_SEL_W+4];
            assign effMode = (cfg_q.bidirEn[p] && !oeSig) ? DM_DIGZ : mode;
            assign d = cfg_q.outData[p];
            always_comb begin
                pinDrive[p] = '0;
                unique case (effMode)
                    DM_ANALOG, DM_DIGZ: pinDrive[p] = '0;
                    DM_PULLUP: begin
                        pinDrive[p].resHigh = d;
                        pinDrive[p].strongLow = ~d;
                    end
                    DM_PULLDN: begin
                        pinDrive[p].strongHigh = d;
                        pinDrive[p].resLow = ~d;
                    end
                    DM_ODLOW: pinDrive[p].strongLow = ~d;
                    DM_ODHIGH: pinDrive[p].strongHigh = d;
                    DM_STRONG: begin
                        pinDrive[p].strongHigh = d;
                        pinDrive[p].strongLow = ~d;
                    end
                    DM_RESUD: begin
                        pinDrive[p].resHigh = d;
                        pinDrive[p].resLow = ~d;
                    end
                endcase
                pinDrive[p].slowSlew = cfg_q.slew[p]
                    & (effMode inside {DM_ODLOW, DM_ODHIGH, DM_STRONG});
                pinDrive[p].regulatedHigh = cfg_q.vselReg[p];
            end
            assign driveOn[p] = pinDrive[p].strongHigh | pinDrive[p].strongLow
                | pinDrive[p].resHigh | pinDrive[p].resLow;
            assign bufOn[p] = (mode != DM_ANALOG) & ~cfg_q.inBufDis[p];
        end
    endgenerate
    always_comb begin
        pinOut = cfg_q.outData;
        pinOe_n = ~driveOn;
        inBufEn = bufOn;
    end
    // ============================================================
    // input sync, pin state, edge interrupts
    logic [PIO_PINS-1:0] sync1_q;
    logic [PIO_PINS-1:0] sync1_d;
    logic [PIO_PINS-1:0] sync2_q;
    logic [PIO_PINS-1:0] sync2_d;
    logic [PIO_PINS-1:0] prev_q;
    logic [PIO_PINS-1:0] prev_d;
    logic [PIO_PINS-1:0] stat_q;
    logic [PIO_PINS-1:0] stat_d;
    logic [PIO_PINS-1:0] hit;
    always_comb begin
        sync1_d = pinIn;
        sync2_d = sync1_q;
        prev_d = sync2_q;
        for (int i = 0; i < PIO_PINS; i++) begin
            hit[i] = bufOn[i] & edgeHit(intType[2*i +: 2], sync2_q[i], prev_q[i]);
        end
        stat_d = (intStatClr ? '0 : stat_q) | hit; // set wins; ignores lowPower
    end
    // sync chain keeps sampling through reset: no false edge after release
    always_ff @(posedge clk) begin
        sync1_q <= sync1_d;
        sync2_q <= sync2_d;
        prev_q <= prev_d;
        if (rst) begin
            stat_q <= '0;
        end else begin
            stat_q <= stat_d;
        end
    end
    assign pinStateRead = sync2_q & bufOn;
    assign intStatus = stat_q;
    assign portIrq = |stat_q;
endmodule : pio_port

//--- src/pio_pkg.sv
// package for the programmable i/o port: widths, codes, carriers
package pio_pkg;
    // ============================================================
    // sizes
    localparam int PIO_PINS = 8;
    localparam int PIO_AUX_W = 16;
    localparam int PIO_SEL_W = 5;
    localparam int PIO_PAIRS = 4;
    // ============================================================
    // pin-form field positions
    localparam int PF_DM_LSB = 1;
    localparam int PF_OUT = 0;
    localparam int PF_SLW = 4;
    localparam int PF_BIE = 5;
    localparam int PF_IBD = 6;
    localparam int PF_VSEL = 7;
    // ============================================================
    // reset values and codes
    localparam logic [2:0] DM_ANALOG = 3'h0;
    localparam logic [2:0] DM_DIGZ = 3'h1;
    localparam logic [2:0] DM_PULLUP = 3'h2;
    localparam logic [2:0] DM_PULLDN = 3'h3;
    localparam logic [2:0] DM_ODLOW = 3'h4;
    localparam logic [2:0] DM_ODHIGH = 3'h5;
    localparam logic [2:0] DM_STRONG = 3'h6;
    localparam logic [2:0] DM_RESUD = 3'h7;
    localparam logic [1:0] RST_CFG_ANALOG = 2'h0;
    localparam logic [1:0] RST_CFG_PULLDN = 2'h1;
    localparam logic [1:0] RST_CFG_PULLUP = 2'h2;
    localparam logic [1:0] INT_OFF = 2'h0;
    localparam logic [1:0] INT_RISE = 2'h1;
    localparam logic [1:0] INT_FALL = 2'h2;
    localparam logic [1:0] INT_BOTH = 2'h3;
    localparam logic [1:0] VTH_HALF_VDD = 2'h0;
    // ============================================================
    // carriers
    typedef enum logic [1:0] {PIO_LOAD_IDLE, PIO_LOAD_COPY, PIO_LOAD_DONE} pio_load_t;
    typedef struct packed {
        logic strongHigh;
        logic strongLow;
        logic resHigh;
        logic resLow;
        logic slowSlew;
        logic regulatedHigh;
    } pio_drive_t;
    typedef struct packed {
        logic [PIO_PINS-1:0] outData;
        logic [PIO_PINS-1:0] dm0;
        logic [PIO_PINS-1:0] dm1;
        logic [PIO_PINS-1:0] dm2;
        logic [PIO_PINS-1:0] slew;
        logic [PIO_PINS-1:0] bidirEn;
        logic [PIO_PINS-1:0] inBufDis;
        logic [PIO_PINS-1:0] vselReg;
    } pio_cfg_t;
endpackage : pio_pkg

//--- dv/pio_port_assertions.sv
// checker bound to the programmable i/o port
`timescale 1ns/1ns
module pio_port_assertions
    import pio_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] pinRdIdx,
    input wire logic [7:0] pinRdData,
    input wire logic [PIO_AUX_W-1:0] auxOe,
    input wire logic [PIO_PINS*PIO_SEL_W-1:0] auxSel,
    input wire logic intStatClr,
    input wire logic [PIO_PINS-1:0] pinOe_n,
    input wire pio_drive_t [PIO_PINS-1:0] pinDrive,
    input wire logic [PIO_PINS-1:0] inBufEn,
    input wire logic [PIO_PINS-1:0] intStatus,
    input wire logic portIrq,
    input wire logic cfgLoaded
);
    // ============================================================
    // decoded view of the pin under readback
    logic [2:0] mode;
    logic o;
    logic bid;
    logic auxOn;
    pio_drive_t dv;
    assign mode = pinRdData[3:1];
    assign o = pinRdData[PF_OUT];
    assign bid = pinRdData[PF_BIE];
    assign dv = pinDrive[pinRdIdx];
    assign auxOn = auxSel[pinRdIdx*PIO_SEL_W+4] && auxOe[auxSel[pinRdIdx*PIO_SEL_W+:4]];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ============================================================
    // assertions
    sequence s_loading; !cfgLoaded ##1 !cfgLoaded; endsequence
    sequence s_loaded; cfgLoaded; endsequence
    a_load_order: assert property ($fell(rst) |-> s_loading ##1 s_loaded)
        else $error("reset config load out of step");
    a_irq_any: assert property (portIrq == (|intStatus))
        else $error("port request differs from status");
    a_status_hold: assert property (!intStatClr |=> (intStatus & $past(intStatus)) == $past(intStatus))
        else $error("status bit dropped without clear");
    a_pull_up: assert property (mode == DM_PULLUP && !bid |-> dv.resHigh == o && dv.strongLow == !o)
        else $error("pull-up drive wrong");
    a_open_drain: assert property (mode == DM_ODLOW && !bid |-> pinOe_n[pinRdIdx] == o && !dv.strongHigh)
        else $error("open-drain drive wrong");
    a_strong_drive: assert property (mode == DM_STRONG && !bid |-> dv.strongHigh == o && dv.strongLow == !o)
        else $error("strong drive wrong");
    a_res_both: assert property (mode == DM_RESUD && !bid |-> dv.resHigh == o && dv.resLow == !o)
        else $error("combined resistive drive wrong");
    a_slew_scope: assert property (dv.slowSlew |-> pinRdData[PF_SLW] && mode inside {[DM_ODLOW:DM_STRONG]})
        else $error("slow slew outside its modes");
    a_bidir_off: assert property (bid && !auxOn |-> pinOe_n[pinRdIdx])
        else $error("bidirectional pin driven without enable");
    a_bidir_on: assert property (bid && auxOn && mode == DM_STRONG |-> !pinOe_n[pinRdIdx])
        else $error("bidirectional pin not driven with enable");
    a_analog_off: assert property (mode == DM_ANALOG |-> !inBufEn[pinRdIdx] && pinOe_n[pinRdIdx])
        else $error("analog pin not fully off");
endmodule : pio_port_assertions
bind pio_port pio_port_assertions pio_port_assertions_inst (.clk, .rst, .pinRdIdx, .pinRdData,
    .auxOe, .auxSel, .intStatClr, .pinOe_n, .pinDrive, .inBufEn, .intStatus, .portIrq, .cfgLoaded);

//--- dv/pio_pin_model.sv
// external circuitry at the port pins
`timescale 1ns/1ns
module pio_pin_model
    import pio_pkg::*;
(
    input wire logic clk,
    input wire pio_drive_t [PIO_PINS-1:0] pinDrive,
    input wire logic [PIO_PINS-1:0] extDrive,
    input wire logic [PIO_PINS-1:0] extLevel,
    output logic [PIO_PINS-1:0] pinIn
);
    // ============================================================
    // level resolution: strong, then external, then resistor, else floating
    logic flip = 1'b0;
    always @(negedge clk) flip <= !flip;
    always_comb begin
        for (int i = 0; i < PIO_PINS; i++) begin
            if (pinDrive[i].strongHigh || pinDrive[i].strongLow) pinIn[i] = pinDrive[i].strongHigh;
            else if (extDrive[i]) pinIn[i] = extLevel[i];
            else if (pinDrive[i].resHigh || pinDrive[i].resLow) pinIn[i] = pinDrive[i].resHigh;
            else pinIn[i] = flip ^ i[0];
        end
    end
endmodule : pio_pin_model

//--- dv/pio_port_tb.sv
// self-checking bench for the programmable i/o port
`timescale 1ns/1ns
module pio_port_tb
    import pio_pkg::*;
;
    logic clk, rst, pinWrEn, intStatClr, lowPower, lvttlSel, thresholdLvttl, portIrq, cfgLoaded;
    logic [1:0] nvResetCfg;
    logic [2:0] portWrSel, pinWrIdx, pinRdIdx;
    logic [7:0] portWrEn, portWrData, pinWrData, pinRdData, pairThreshSel, pairThresh;
    logic [7:0] pinIn, pinOut, pinOe_n, inBufEn, pinStateRead, intStatus, extDrive, extLevel;
    logic [15:0] auxOe, intType;
    logic [39:0] auxSel;
    pio_drive_t [PIO_PINS-1:0] pinDrive;
    int badCount = 0;
    int checksDone = 0;
    int cycles = 0;
    pio_port pio_port_inst (.clk, .rst, .nvResetCfg, .portWrEn, .portWrSel, .portWrData, .pinWrEn,
        .pinWrIdx, .pinWrData, .pinRdIdx, .pinRdData, .auxOe, .auxSel, .intType, .intStatClr,
        .lowPower, .lvttlSel, .pairThreshSel, .pinIn, .pinOut, .pinOe_n, .pinDrive, .inBufEn,
        .thresholdLvttl, .pairThresh, .pinStateRead, .intStatus, .portIrq, .cfgLoaded);
    pio_pin_model pio_pin_model_inst (.clk, .pinDrive, .extDrive, .extLevel, .pinIn);
    // ============================================================
    // tasks
    task results();
        if (badCount == 0 && checksDone > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    task chk(input logic [7:0] got, input logic [7:0] want);
        checksDone++;
        if (got !== want) begin
            badCount++;
            $display("Error at %0t: got %h, expected %h", $time, got, want);
        end
    endtask : chk
    task portWr(input logic [2:0] sel, input logic [7:0] en, input logic [7:0] d);
        {portWrSel, portWrEn, portWrData} = {sel, en, d};
        @(negedge clk);
        portWrEn = 8'h00;
        @(negedge clk);
    endtask : portWr
    task pinWr(input logic [2:0] i, input logic [7:0] d);
        {pinWrEn, pinWrIdx, pinWrData} = {1'b1, i, d};
        @(negedge clk);
        pinWrEn = 1'b0;
        @(negedge clk);
    endtask : pinWr
    task rdChk(input logic [2:0] i, input logic [7:0] want);
        pinRdIdx = i;
        #1 chk(pinRdData, want);
        @(negedge clk);
    endtask : rdChk
    task edgeChk(input logic lvl, input logic [7:0] want);
        intStatClr = 1'b1;
        @(negedge clk);
        intStatClr = 1'b0;
        extLevel[0] = lvl;
        repeat (4) @(negedge clk);
        chk(intStatus, want);
    endtask : edgeChk
    // ============================================================
    // clock, timeout, tests
    always #25 clk = !clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            badCount++;
            results();
        end
    end
    initial begin
        {clk, rst, pinWrEn, intStatClr, lowPower, lvttlSel} = 6'b010000;
        {portWrSel, pinWrIdx, pinRdIdx, portWrEn, portWrData, pinWrData, pairThreshSel} = '0;
        {extDrive, extLevel, auxOe, intType, auxSel} = '0;
        nvResetCfg = RST_CFG_PULLUP;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        chk({7'h0, cfgLoaded}, 8'h01);
        for (int i = 0; i < 8; i++) rdChk(i[2:0], 8'h04);
        portWr(3'h3, 8'hff, 8'hff);
        portWr(3'h0, 8'h0f, 8'h05);
        pinWr(3'h3, 8'h0f);
        pinWr(3'h4, 8'h08);
        chk(pinOut, 8'h0d);
        rdChk(3'h3, 8'h0f);
        rdChk(3'h2, 8'h0d);
        rdChk(3'h4, 8'h08);
        chk({4'h0, pinDrive[4][5:2]}, 8'h04);
        chk({4'h0, pinDrive[3][5:2]}, 8'h02);
        chk({4'h0, pinDrive[0][5:2]}, 8'h08);
        pinWr(3'h5, 8'h9c);
        pinWr(3'h6, 8'h14);
        pinWr(3'h7, 8'h00);
        chk({6'h0, pinDrive[5][1:0]}, 8'h03);
        chk({6'h0, pinDrive[6][1:0]}, 8'h00);
        rdChk(3'h7, 8'h00);
        rdChk(3'h5, 8'h9c);
        pinWr(3'h6, 8'h1e);
        chk({6'h0, pinDrive[6][1:0]}, 8'h00);
        pinWr(3'h1, 8'h2c);
        rdChk(3'h1, 8'h2c);
        auxSel[9:5] = 5'h15;
        for (int a = 1; a >= 0; a--) begin
            auxOe[5] = a[0];
            #1 chk(pinOe_n & 8'h02, {6'h0, !a[0], 1'b0});
            @(negedge clk);
        end
        lvttlSel = 1'b1;
        pairThreshSel = 8'he4;
        @(negedge clk);
        chk({7'h0, thresholdLvttl}, 8'h01);
        chk(pairThresh, 8'he4);
        pinWr(3'h0, 8'h02);
        {lowPower, extDrive} = 9'h101;
        for (int t = 0; t < 4; t++) begin
            intType[1:0] = t[1:0];
            edgeChk(1'b1, {7'h0, t[0]});
            chk(pinStateRead & 8'h01, 8'h01);
            edgeChk(1'b1, 8'h00);
            edgeChk(1'b0, {7'h0, t[1]});
            chk({7'h0, portIrq}, {7'h0, t[1]});
        end
        pinWr(3'h0, 8'h42);
        chk(inBufEn & 8'h01, 8'h00);
        edgeChk(1'b1, 8'h00);
        results();
    end
endmodule : pio_port_tb
